// ### common/maxaddr_pkg.sv
package maxaddr_pkg;
    // ----------------------------------------------------------------
    // command codes and subcommands
    // ----------------------------------------------------------------
    localparam logic [7:0]  CMD_SET_MAX        = 8'hf9;
    localparam logic [7:0]  CMD_READ_NATIVE    = 8'hf8;
    localparam logic [7:0]  CMD_SET_MAX_EXT    = 8'h37;
    localparam logic [7:0]  CMD_READ_SECTORS   = 8'h20;
    localparam logic [7:0]  CMD_WRITE_SECTORS  = 8'h30;
    localparam logic [7:0]  SUB_SET_PASSWORD   = 8'h01;
    localparam logic [7:0]  SUB_LOCK           = 8'h02;
    localparam logic [7:0]  SUB_UNLOCK         = 8'h03;
    localparam logic [7:0]  SUB_FREEZE         = 8'h04;
    // ----------------------------------------------------------------
    // taskfile field positions
    // ----------------------------------------------------------------
    localparam int          SC_PERSIST_BIT     = 0;
    localparam int          DH_LBA_BIT         = 6;
    localparam int          ERR_ABORT_BIT      = 2;
    localparam int          ST_BUSY_BIT        = 7;
    localparam int          ST_READY_BIT       = 6;
    localparam int          ST_FAULT_BIT       = 5;
    localparam int          ST_SEEK_BIT        = 4;
    localparam int          ST_DRQ_BIT         = 3;
    localparam int          ST_ERR_BIT         = 0;
    // ----------------------------------------------------------------
    // capacity, geometry and data sector layout
    // ----------------------------------------------------------------
    localparam logic [47:0] NATIVE_MAX         = 48'h0000_2000_0000;
    localparam logic [47:0] LBA28_MAX          = 48'h0000_0fff_ffff;
    localparam logic        LBA48_SUPPORTED    = 1'b1;
    localparam logic [3:0]  CHS_HEADS          = 4'hf;
    localparam logic [7:0]  CHS_SECTORS        = 8'h3f;
    localparam logic [7:0]  SECTOR_WORDS_LAST  = 8'hff;
    localparam logic [7:0]  PW_FIRST_WORD      = 8'h01;
    localparam logic [7:0]  PW_LAST_WORD       = 8'h10;
    localparam int          PW_WORDS           = 16;
    localparam logic [2:0]  UNLOCK_TRIES       = 3'h5;
    // ----------------------------------------------------------------
    // controller register map (apb byte offsets)
    // ----------------------------------------------------------------
    localparam logic [7:0]  REG_TF_A           = 8'h00;
    localparam logic [7:0]  REG_TF_B           = 8'h04;
    localparam logic [7:0]  REG_CTRL           = 8'h08;
    localparam logic [7:0]  REG_DATA           = 8'h0c;
    localparam logic [7:0]  REG_STAT           = 8'h10;
    localparam logic [7:0]  REG_RESULT         = 8'h14;
    localparam int          CTRL_GO_BIT        = 0;
    localparam int          CTRL_HRST_BIT      = 1;
endpackage : maxaddr_pkg

// ### common/taskfile_if.sv
interface taskfile_if;
    logic        cmd_stb;
    logic [7:0]  feature;
    logic [7:0]  sec_cnt;
    logic [7:0]  sec_num;
    logic [7:0]  cyl_lo;
    logic [7:0]  cyl_hi;
    logic [7:0]  dev_head;
    logic [7:0]  command;
    logic        data_stb;
    logic [15:0] data;
    logic        hard_reset;
    logic        busy;
    logic        drq;
    logic        done;
    logic [7:0]  command_fault_flags;
    logic [7:0]  device_condition_flags;
    logic [7:0]  ret_sec_num;
    logic [7:0]  ret_cyl_lo;
    logic [7:0]  ret_cyl_hi;
    logic [7:0]  ret_dev_head;

    modport dev (
        input  cmd_stb, feature, sec_cnt, sec_num, cyl_lo, cyl_hi, dev_head, command,
        input  data_stb, data, hard_reset,
        output busy, drq, done, command_fault_flags, device_condition_flags,
        output ret_sec_num, ret_cyl_lo, ret_cyl_hi, ret_dev_head
    );
    modport host (
        output cmd_stb, feature, sec_cnt, sec_num, cyl_lo, cyl_hi, dev_head, command,
        output data_stb, data, hard_reset,
        input  busy, drq, done, command_fault_flags, device_condition_flags,
        input  ret_sec_num, ret_cyl_lo, ret_cyl_hi, ret_dev_head
    );
endinterface : taskfile_if

// ### hdl/maxaddr_dev.sv
module maxaddr_dev
    import maxaddr_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        offset_mode_i,
    input  wire logic        nv_valid_i,
    input  wire logic [47:0] nv_max_i,
    output logic             nv_wr_o,
    output logic [47:0]      nv_max_o,
    output logic [31:0]      id_w61_60_o,
    output logic [63:0]      id_w103_100_o,
    taskfile_if.dev          tf
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_XFER = 2'b01,
        ST_DONE = 2'b10
    } state_t;

    state_t      state_r;
    logic        xfer_unlock_r;
    logic [7:0]  word_cnt_r;
    logic [15:0] pw_r [PW_WORDS];
    logic [15:0] pw_in_r [PW_WORDS];
    logic        load_r;
    logic [47:0] cur_max_r;
    logic        prev_native_r;
    logic        persist_done_r;
    logic        hpa_ext_r;
    logic        locked_r;
    logic        frozen_r;
    logic [2:0]  tries_r;
    logic        abort_r;
    logic        pw_match;

    // ----------------------------------------------------------------
    // address helpers
    // ----------------------------------------------------------------
    function automatic logic [47:0] chs_max(input logic [15:0] cyl);
        logic [47:0] prod;
        prod = 48'(cyl) * (48'(CHS_HEADS) + 48'h1) * 48'(CHS_SECTORS);
        return prod - 48'h1;
    endfunction : chs_max

    logic        lba_mode;
    logic        persist;
    logic [47:0] lba_req;
    logic [47:0] req_max;
    logic [47:0] new_max;
    logic        set_bad;

    always_comb begin
        lba_mode = tf.dev_head[DH_LBA_BIT];
        persist  = tf.sec_cnt[SC_PERSIST_BIT];
        lba_req  = {20'h0, tf.dev_head[3:0], tf.cyl_hi, tf.cyl_lo, tf.sec_num};
        req_max  = lba_mode ? lba_req : chs_max({tf.cyl_hi, tf.cyl_lo});
        new_max  = req_max;
        if (NATIVE_MAX > LBA28_MAX && req_max == LBA28_MAX) begin
            new_max = NATIVE_MAX;
        end
        set_bad = locked_r || frozen_r
               || hpa_ext_r
               || (persist && persist_done_r)
               || (persist && offset_mode_i)
               || (req_max > NATIVE_MAX);
    end

    always_comb begin
        pw_match = 1'b1;
        for (int i = 0; i < PW_WORDS; i++) begin
            if (pw_r[i] != pw_in_r[i]) begin
                pw_match = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // command sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_r       <= ST_IDLE;
            xfer_unlock_r <= 1'b0;
            word_cnt_r    <= 8'h00;
            abort_r       <= 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (tf.cmd_stb) begin
                        state_r <= ST_DONE;
                        abort_r <= 1'b1;
                        if (tf.command == CMD_SET_MAX && prev_native_r) begin
                            abort_r <= set_bad;
                        end else if (tf.command == CMD_SET_MAX) begin
                            unique case (tf.feature)
                                SUB_SET_PASSWORD: begin
                                    if (!(locked_r || frozen_r)) begin
                                        abort_r       <= 1'b0;
                                        state_r       <= ST_XFER;
                                        xfer_unlock_r <= 1'b0;
                                        word_cnt_r    <= 8'h00;
                                    end
                                end
                                SUB_LOCK: abort_r <= locked_r || frozen_r;
                                SUB_UNLOCK: begin
                                    if (!frozen_r && tries_r != 3'h0) begin
                                        abort_r       <= 1'b0;
                                        state_r       <= ST_XFER;
                                        xfer_unlock_r <= 1'b1;
                                        word_cnt_r    <= 8'h00;
                                    end
                                end
                                SUB_FREEZE: abort_r <= frozen_r;
                                default: abort_r <= 1'b1;
                            endcase
                        end else if (tf.command == CMD_READ_SECTORS
                                  || tf.command == CMD_WRITE_SECTORS) begin
                            abort_r <= lba_req > cur_max_r;
                        end else begin
                            abort_r <= 1'b0;
                        end
                    end
                end
                ST_XFER: begin
                    if (tf.data_stb) begin
                        word_cnt_r <= word_cnt_r + 8'h01;
                        if (word_cnt_r == SECTOR_WORDS_LAST) begin
                            state_r <= ST_DONE;
                            abort_r <= xfer_unlock_r && !pw_match;
                        end
                    end
                end
                ST_DONE: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // password capture
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < PW_WORDS; i++) begin
                pw_in_r[i] <= 16'h0000;
            end
        end else if (state_r == ST_XFER && tf.data_stb
                     && word_cnt_r >= PW_FIRST_WORD && word_cnt_r <= PW_LAST_WORD) begin
            pw_in_r[4'(word_cnt_r - PW_FIRST_WORD)] <= tf.data;
        end
    end

    // ----------------------------------------------------------------
    // security state
    // ----------------------------------------------------------------
    wire xfer_end = state_r == ST_XFER && tf.data_stb && word_cnt_r == SECTOR_WORDS_LAST;
    wire sub_ok   = state_r == ST_IDLE && tf.cmd_stb && tf.command == CMD_SET_MAX
                    && !prev_native_r;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < PW_WORDS; i++) begin
                pw_r[i] <= 16'h0000;
            end
            locked_r <= 1'b0;
            frozen_r <= 1'b0;
        end else if (xfer_end && !xfer_unlock_r) begin
            pw_r     <= pw_in_r;
            locked_r <= 1'b0;
        end else if (xfer_end && pw_match) begin
            locked_r <= 1'b0;
        end else if (sub_ok && tf.feature == SUB_LOCK && !frozen_r) begin
            locked_r <= 1'b1;
        end else if (sub_ok && tf.feature == SUB_FREEZE && !frozen_r) begin
            frozen_r <= 1'b1;
            locked_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i || tf.hard_reset) begin
            tries_r <= UNLOCK_TRIES;
        end else if (xfer_end && xfer_unlock_r && !pw_match) begin
            tries_r <= tries_r - 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // maximum address state
    // ----------------------------------------------------------------
    wire set_ok = state_r == ST_IDLE && tf.cmd_stb && tf.command == CMD_SET_MAX
                  && prev_native_r && !set_bad;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            load_r    <= 1'b1;
            cur_max_r <= NATIVE_MAX;
        end else if (load_r) begin
            load_r    <= 1'b0;
            cur_max_r <= nv_valid_i ? nv_max_i : NATIVE_MAX;
        end else if (set_ok) begin
            cur_max_r <= new_max;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i || tf.hard_reset) begin
            persist_done_r <= 1'b0;
        end else if (set_ok && persist) begin
            persist_done_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            nv_wr_o  <= 1'b0;
            nv_max_o <= 48'h0;
        end else begin
            nv_wr_o <= set_ok && persist;
            if (set_ok && persist) begin
                nv_max_o <= new_max;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            prev_native_r <= 1'b0;
            hpa_ext_r     <= 1'b0;
        end else if (state_r == ST_IDLE && tf.cmd_stb) begin
            prev_native_r <= tf.command == CMD_READ_NATIVE;
            if (tf.command == CMD_SET_MAX_EXT) begin
                hpa_ext_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            id_w61_60_o   <= NATIVE_MAX > LBA28_MAX ? LBA28_MAX[31:0] : NATIVE_MAX[31:0];
            id_w103_100_o <= 64'h0;
        end else begin
            id_w61_60_o   <= cur_max_r > LBA28_MAX ? LBA28_MAX[31:0] : cur_max_r[31:0];
            id_w103_100_o <= LBA48_SUPPORTED ? {16'h0, cur_max_r} : 64'h0;
        end
    end

    // ----------------------------------------------------------------
    // answer registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tf.ret_sec_num  <= 8'h00;
            tf.ret_cyl_lo   <= 8'h00;
            tf.ret_cyl_hi   <= 8'h00;
            tf.ret_dev_head <= 8'h00;
        end else if (state_r == ST_IDLE && tf.cmd_stb && tf.command == CMD_SET_MAX
                     && prev_native_r) begin
            if (lba_mode) begin
                tf.ret_sec_num  <= set_ok ? new_max[7:0]   : cur_max_r[7:0];
                tf.ret_cyl_lo   <= set_ok ? new_max[15:8]  : cur_max_r[15:8];
                tf.ret_cyl_hi   <= set_ok ? new_max[23:16] : cur_max_r[23:16];
                tf.ret_dev_head <= {tf.dev_head[7:4], set_ok ? new_max[27:24] : cur_max_r[27:24]};
            end else begin
                tf.ret_sec_num  <= CHS_SECTORS;
                tf.ret_cyl_lo   <= tf.cyl_lo;
                tf.ret_cyl_hi   <= tf.cyl_hi;
                tf.ret_dev_head <= {tf.dev_head[7:4], CHS_HEADS};
            end
        end
    end

    always_comb begin
        tf.busy = state_r != ST_IDLE;
        tf.drq  = state_r == ST_XFER;
        tf.done = state_r == ST_DONE;
        tf.command_fault_flags = 8'h00;
        tf.command_fault_flags[ERR_ABORT_BIT] = abort_r;
        tf.device_condition_flags = 8'h00;
        tf.device_condition_flags[ST_BUSY_BIT]  = state_r != ST_IDLE && state_r != ST_DONE;
        tf.device_condition_flags[ST_READY_BIT] = 1'b1;
        tf.device_condition_flags[ST_FAULT_BIT] = 1'b0;
        tf.device_condition_flags[ST_SEEK_BIT]  = 1'b1;
        tf.device_condition_flags[ST_DRQ_BIT]   = state_r == ST_XFER;
        tf.device_condition_flags[ST_ERR_BIT]   = abort_r;
    end
endmodule : maxaddr_dev

// ### hdl/maxaddr_host.sv
module maxaddr_host
    import maxaddr_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    taskfile_if.host         tf
);
    logic [31:0] tf_a_r;
    logic [31:0] tf_b_r;
    logic [7:0]  err_r;
    logic [7:0]  stat_r;
    logic [31:0] result_r;
    logic        wait_r;

    wire access   = psel_i && penable_i;
    wire data_wr  = access && pwrite_i && paddr_i == REG_DATA;
    wire mapped   = paddr_i == REG_TF_A || paddr_i == REG_TF_B || paddr_i == REG_CTRL
                 || paddr_i == REG_DATA || paddr_i == REG_STAT || paddr_i == REG_RESULT;

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    always_comb begin
        pready_o  = data_wr ? tf.drq : 1'b1;
        pslverr_o = access && !mapped;
        prdata_o  = 32'h0;
        unique case (paddr_i)
            REG_TF_A:   prdata_o = tf_a_r;
            REG_TF_B:   prdata_o = tf_b_r;
            REG_STAT:   prdata_o = {14'h0, tf.drq, wait_r, stat_r, err_r};
            REG_RESULT: prdata_o = result_r;
            default:    prdata_o = 32'h0;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tf_a_r <= 32'h0;
            tf_b_r <= 32'h0;
        end else if (access && pwrite_i && paddr_i == REG_TF_A) begin
            tf_a_r <= pwdata_i;
        end else if (access && pwrite_i && paddr_i == REG_TF_B) begin
            tf_b_r <= pwdata_i;
        end
    end

    // ----------------------------------------------------------------
    // taskfile drive
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tf.cmd_stb    <= 1'b0;
            tf.hard_reset <= 1'b0;
            tf.data_stb   <= 1'b0;
            tf.data       <= 16'h0;
            wait_r        <= 1'b0;
        end else begin
            tf.cmd_stb    <= access && pwrite_i && paddr_i == REG_CTRL
                             && pwdata_i[CTRL_GO_BIT] && !wait_r && !tf.busy;
            tf.hard_reset <= access && pwrite_i && paddr_i == REG_CTRL
                             && pwdata_i[CTRL_HRST_BIT];
            tf.data_stb   <= data_wr && tf.drq;
            if (data_wr && tf.drq) begin
                tf.data <= pwdata_i[15:0];
            end
            if (tf.cmd_stb) begin
                wait_r <= 1'b1;
            end else if (tf.done) begin
                wait_r <= 1'b0;
            end
        end
    end

    always_comb begin
        tf.feature  = tf_a_r[7:0];
        tf.sec_cnt  = tf_a_r[15:8];
        tf.sec_num  = tf_a_r[23:16];
        tf.cyl_lo   = tf_a_r[31:24];
        tf.cyl_hi   = tf_b_r[7:0];
        tf.dev_head = tf_b_r[15:8];
        tf.command  = tf_b_r[23:16];
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            err_r    <= 8'h0;
            stat_r   <= 8'h0;
            result_r <= 32'h0;
        end else if (tf.done) begin
            err_r    <= tf.command_fault_flags;
            stat_r   <= tf.device_condition_flags;
            result_r <= {tf.ret_dev_head, tf.ret_cyl_hi, tf.ret_cyl_lo, tf.ret_sec_num};
        end
    end
endmodule : maxaddr_host

// ### verif/maxaddr_asserts.sv
module maxaddr_asserts
    import maxaddr_pkg::*;
(
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic       cmd_stb,
    input wire logic       hard_reset,
    input wire logic [7:0] command,
    input wire logic [7:0] sec_cnt,
    input wire logic [7:0] dev_head,
    input wire logic       busy,
    input wire logic       done,
    input wire logic [7:0] command_fault_flags,
    input wire logic [7:0] device_condition_flags,
    input wire logic [7:0] ret_sec_num,
    input wire logic [7:0] ret_dev_head
);
    logic [7:0] last_r;
    logic       set_r;
    logic       pers_r;
    wire        ok = done && set_r && !command_fault_flags[ERR_ABORT_BIT];
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            last_r <= 8'h00;
            set_r  <= 1'b0;
        end else if (cmd_stb && !busy) begin
            last_r <= command;
            set_r  <= (command == CMD_SET_MAX) && (last_r == CMD_READ_NATIVE);
        end
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i || hard_reset)
            pers_r <= 1'b0;
        else if (ok && sec_cnt[SC_PERSIST_BIT])
            pers_r <= 1'b1;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        cmd_stb && !busy;
    endsequence
    a_busy_on_take: assert property (s_take |=> busy)
        else $error("busy missing after command");
    a_native_done: assert property (s_take ##0 command == CMD_READ_NATIVE |=> done)
        else $error("native read not completed");
    a_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_done_idle: assert property (done |=> !busy)
        else $error("busy after done");
    a_abort_error: assert property (done && command_fault_flags[ERR_ABORT_BIT]
        |-> device_condition_flags[ST_ERR_BIT])
        else $error("abort without error status");
    a_fault_clear: assert property (done |-> !device_condition_flags[ST_FAULT_BIT])
        else $error("device fault set");
    a_chs_result: assert property (ok && !dev_head[DH_LBA_BIT] |-> ret_sec_num == CHS_SECTORS
        && ret_dev_head[3:0] == CHS_HEADS)
        else $error("chs result wrong");
    a_persist_once: assert property (done && set_r && sec_cnt[SC_PERSIST_BIT] && pers_r
        |-> command_fault_flags[ERR_ABORT_BIT])
        else $error("second persistent setting accepted");
endmodule : maxaddr_asserts

// ### verif/tb_top.sv
module tb_top;
    import maxaddr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        offs = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, st, id61;
    logic [63:0] id103;
    logic        pready, pslverr, err;
    int          failures = 0;
    int          comparisons = 0;
    logic        nvw, dq;
    logic        nvv = 1'b0;
    logic [47:0] nvo;
    logic [47:0] nvs = 48'h0;
    logic [31:0] pw = 32'h0;
    int          nwr = 0;
    always #50 mclk_i = ~mclk_i;
    // nonvolatile store that survives rst_i
    always @(posedge mclk_i) begin
        if (nvw === 1'b1) begin
            nvs <= nvo;
            nwr <= nwr + 1;
        end
    end
    taskfile_if tf_i ();
    maxaddr_dev maxaddr_dev_i (.mclk_i(mclk_i), .rst_i(rst_i), .offset_mode_i(offs),
        .nv_valid_i(nvv), .nv_max_i(nvs), .nv_wr_o(nvw), .nv_max_o(nvo), .id_w61_60_o(id61),
        .id_w103_100_o(id103), .tf(tf_i.dev));
    maxaddr_host maxaddr_host_i (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tf(tf_i.host));
    maxaddr_asserts maxaddr_asserts_i (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_stb(tf_i.cmd_stb),
        .hard_reset(tf_i.hard_reset), .command(tf_i.command), .sec_cnt(tf_i.sec_cnt),
        .dev_head(tf_i.dev_head), .busy(tf_i.busy), .done(tf_i.done),
        .command_fault_flags(tf_i.command_fault_flags), .ret_sec_num(tf_i.ret_sec_num),
        .device_condition_flags(tf_i.device_condition_flags), .ret_dev_head(tf_i.ret_dev_head));
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic end_sim;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            failures++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk_i);
    endtask : apb
    task automatic issue(input logic [7:0] c, f, s, input logic [27:0] v, input logic l);
        int n;
        n = 0;
        apb(1'b1, REG_TF_A, {v[15:8], v[7:0], s, f});
        apb(1'b1, REG_TF_B, {8'h00, c, 1'b1, l, 2'b10, v[27:24], v[23:16]});
        apb(1'b1, REG_CTRL, 32'h1);
        repeat (4) @(posedge mclk_i);
        apb(1'b0, REG_STAT, 32'h0);
        dq = rd[17];
        for (int i = 0; i < 256 && dq; i++) begin
            apb(1'b1, REG_DATA, (i >= 1 && i <= 16) ? pw + i : 32'h0);
        end
        do begin
            apb(1'b0, REG_STAT, 32'h0);
            n++;
        end while (rd[16:15] !== 2'b00 && n < 50);
        if (rd[16:15] !== 2'b00) begin
            failures++;
            end_sim();
        end
        st = rd;
        apb(1'b0, REG_RESULT, 32'h0);
    endtask : issue
    task automatic setmax(input logic [7:0] s, input logic [27:0] v, input logic l);
        issue(CMD_READ_NATIVE, 8'h00, 8'h00, 28'h0, 1'b1);
        issue(CMD_SET_MAX, 8'h00, s, v, l);
    endtask : setmax
    task automatic ab(input logic e);
        chk({29'h0, st[2], st[8], st[13]}, {29'h0, e, e, 1'b0});
    endtask : ab
    initial begin
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        apb(1'b0, 8'h18, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        setmax(8'h00, 28'h0123456, 1'b1);
        ab(1'b0);
        chk({4'h0, rd[27:0]}, 32'h0123456);
        chk(id61, 32'h0123456);
        chk(id103[31:0], 32'h0123456);
        issue(CMD_READ_SECTORS, 8'h00, 8'h01, 28'h0123457, 1'b1);
        ab(1'b1);
        offs <= 1'b1;
        setmax(8'h01, 28'h0100000, 1'b1);
        ab(1'b1);
        offs <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (i == 2)
                apb(1'b1, REG_CTRL, 32'h2);
            setmax(8'h01, 28'h0100000, 1'b1);
            ab(i == 1);
        end
        setmax(8'h00, LBA28_MAX[27:0], 1'b1);
        chk(id61, LBA28_MAX[31:0]);
        chk(id103[31:0], NATIVE_MAX[31:0]);
        setmax(8'h00, 28'h301005a, 1'b0);
        chk({4'h0, rd[27:0]}, 32'h0f01003f);
        chk(id61, 32'h0003efff);
        issue(CMD_SET_MAX, SUB_FREEZE, 8'h00, 28'h0, 1'b1);
        ab(1'b0);
        setmax(8'h00, 28'h0100000, 1'b1);
        ab(1'b1);
        chk(nwr, 32'h2);
        chk(nvs[31:0], 32'h0100000);
        nvv <= 1'b1;
        rst_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk(id61, 32'h0100000);
        pw = 32'h1000;
        issue(CMD_SET_MAX, SUB_SET_PASSWORD, 8'h00, 28'h0, 1'b1);
        chk(dq, 1'b1);
        ab(1'b0);
        issue(CMD_SET_MAX, SUB_LOCK, 8'h00, 28'h0, 1'b1);
        ab(1'b0);
        setmax(8'h00, 28'h0100000, 1'b0);
        ab(1'b1);
        issue(CMD_SET_MAX, SUB_SET_PASSWORD, 8'h00, 28'h0, 1'b1);
        ab(1'b1);
        pw = 32'h2000;
        for (int i = 0; i < 6; i++) begin
            issue(CMD_SET_MAX, SUB_UNLOCK, 8'h00, 28'h0, 1'b1);
            chk(dq, i < 5);
            ab(1'b1);
        end
        apb(1'b1, REG_CTRL, 32'h2);
        pw = 32'h1000;
        issue(CMD_SET_MAX, SUB_UNLOCK, 8'h00, 28'h0, 1'b1);
        ab(1'b0);
        setmax(8'h00, 28'h0200000, 1'b1);
        ab(1'b0);
        issue(CMD_SET_MAX_EXT, 8'h00, 8'h00, 28'h0, 1'b1);
        setmax(8'h00, 28'h0300000, 1'b1);
        ab(1'b1);
        end_sim();
    end
endmodule : tb_top
